// ### logic/pcfc_pkg.sv
`default_nettype none
package pcfc_pkg;
  // register indices on the device port
  localparam logic [3:0] REG_WPROT = 4'h0;
  localparam logic [3:0] REG_USB_SEL = 4'h1;
  localparam logic [3:0] REG_USB_DIV = 4'h2;
  localparam logic [3:0] REG_HS_SEL = 4'h3;
  localparam logic [3:0] REG_HS_DIV = 4'h4;
  localparam logic [3:0] REG_I3C_SEL = 4'h5;
  localparam logic [3:0] REG_I3C_DIV = 4'h6;
  localparam logic [3:0] REG_CKO = 4'h7;
  localparam logic [3:0] REG_FREQ = 4'h8;
  localparam logic [3:0] REG_LDO = 4'h9;
  localparam logic [3:0] REG_SBY = 4'hA;
  localparam logic [3:0] REG_RUN = 4'hB;
  localparam logic [3:0] REG_FLL_EN = 4'hC;
  localparam logic [3:0] REG_FLL_MUL = 4'hD;
  localparam logic [3:0] REG_STAT = 4'hE;
  // per channel select and divider index: usb, usb high speed, i3c
  localparam int NCH = 3;
  localparam logic [2:0][3:0] CH_SEL_REG = {REG_I3C_SEL, REG_HS_SEL, REG_USB_SEL};
  localparam logic [2:0][3:0] CH_DIV_REG = {REG_I3C_DIV, REG_HS_DIV, REG_USB_DIV};
  // field positions
  localparam int WP_CLK_BIT = 0;
  localparam int WP_LP_BIT = 1;
  localparam int CKO_EN_BIT = 7;
  localparam int LDO_STOP_BIT = 0;
  localparam int LDO_KEEP_BIT = 1;
  localparam int ONE_BIT = 0;
  localparam int STAT_STABLE_BIT = 0;
  // field values and reset values
  localparam logic [1:0] WP_UNLOCK_ALL = 2'h3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int OSC_STAB_NS = 1000;
  localparam logic [7:0] OSC_STAB_CYC =
    8'((OSC_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int FLL_WAIT_NS = 2000;
  localparam logic [7:0] FLL_WAIT_CYC =
    8'((FLL_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // controller apb offsets and fields
  localparam logic [11:0] APB_CTRL = 12'h000;
  localparam logic [11:0] APB_STAT = 12'h004;
  localparam logic [11:0] APB_ACC = 12'h008;
  localparam logic [11:0] APB_RDATA = 12'h00C;
  localparam int CTL_START_BIT = 0;
  localparam int CTL_FLL_BIT = 1;
  localparam int CTL_SBY_BIT = 2;
  localparam int CTL_FREQ_LSB = 4;
  localparam int CTL_MUL_LSB = 8;
  localparam int ACC_DATA_LSB = 8;
  localparam int ACC_WE_BIT = 16;
  localparam int ACC_GO_BIT = 31;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_ERR_BIT = 2;
  localparam int ST_STABLE_BIT = 3;
endpackage
`default_nettype wire

// ### logic/pcfc_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pcfc_if;
  // register request from the controller, held until ack
  logic req;
  logic we;
  logic [3:0] addr;
  logic [7:0] wdata;
  // answer from the clock block, one cycle pulse with data
  logic [7:0] rdata;
  logic ack;
  modport dev (input req, we, addr, wdata, output rdata, ack);
  modport host (output req, we, addr, wdata, input rdata, ack);
endinterface
`default_nettype wire

// ### logic/pcfc_tick_div.sv
`timescale 1ns/1ns
`default_nettype none
module pcfc_tick_div (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // source tick and setting
  input wire logic run_in,
  input wire logic tick_in,
  input wire logic [2:0] div_in,
  // divided tick and square wave
  output logic tick_out,
  output logic level_out
);
  typedef struct packed {
    logic [2:0] cnt; // source ticks seen
    logic tick; // divided tick
    logic level; // toggles per divided tick
  } pcfc_div_t;
  pcfc_div_t d_r;
  pcfc_div_t d_nxt;

  // divide by div_in plus one; a silent source simply stops the output
  always_comb
  begin
    d_nxt = d_r;
    d_nxt.tick = 1'b0;
    if (!run_in)
    begin
      d_nxt.cnt = 3'h0;
      d_nxt.level = 1'b0;
    end
    else if (tick_in)
    begin
      if (d_r.cnt >= div_in)
      begin
        d_nxt.cnt = 3'h0;
        d_nxt.tick = 1'b1;
        d_nxt.level = !d_r.level;
      end
      else
      begin
        d_nxt.cnt = d_r.cnt + 3'h1;
      end
    end
  end

  // state register
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      d_r <= '0;
    else
      d_r <= d_nxt;
  end

  assign tick_out = d_r.tick;
  assign level_out = d_r.level;
endmodule
`default_nettype wire

// ### logic/pcfc_clk_dev.sv
`timescale 1ns/1ns
`default_nettype none
module pcfc_clk_dev (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // register port from the controller
  pcfc_if.dev bus,
  // boot option straps, asynchronous
  input wire logic [2:0] opt_word_ns_freq_in,
  input wire logic [2:0] opt_word_sec_freq_in,
  input wire logic option_word_select_in,
  input wire logic fast_osc_boot_enable_in,
  // other source ticks, same clock
  input wire logic [13:0] src_tick_in,
  // generated clock enables
  output logic usb_fixed_rate_clock_out,
  output logic usb_hs_controller_clock_out,
  output logic i3c_clock_out,
  // external clock output pin and status
  output logic external_clock_output_out,
  output logic external_clock_output_oe_out,
  output logic fast_osc_stable_flag_out
);
  typedef struct packed {
    logic [8:0] strap_s1; // first sync stage
    logic [8:0] strap_s2; // second sync stage
    logic loaded; // boot option taken
    logic [1:0] wprot; // unlock bits
    logic [2:0][3:0] sel; // channel source selects
    logic [2:0][2:0] div; // channel dividers
    logic [7:0] cko; // enable, divider, select
    logic [2:0] freq; // oscillator frequency field
    logic ldo_stop;
    logic ldo_keep;
    logic sby_keep;
    logic run;
    logic fll_en;
    logic [7:0] fll_mul;
    logic [7:0] stab_cnt; // start-up counter
    logic stable;
    logic ack;
    logic [7:0] rdata;
  } pcfc_dev_t;
  pcfc_dev_t s_r;
  pcfc_dev_t s_nxt;
  logic [7:0] rd_val; // read mux
  logic osc_tick; // oscillator rate enable
  logic [15:0] src_ticks; // selectable sources
  logic [2:0] ch_tick; // channel outputs
  logic cko_level; // pin square wave

  // sources: always-on, oscillator, then the external ticks
  assign src_ticks = {src_tick_in, osc_tick, 1'b1};

  // register read mux, reserved bits read zero
  always_comb
  begin
    rd_val = pcfc_pkg::RST_BYTE;
    case (bus.addr)
      pcfc_pkg::REG_WPROT: rd_val[1:0] = s_r.wprot;
      pcfc_pkg::REG_CKO: rd_val = s_r.cko;
      pcfc_pkg::REG_FREQ: rd_val[2:0] = s_r.freq;
      pcfc_pkg::REG_LDO: rd_val[1:0] = {s_r.ldo_keep, s_r.ldo_stop};
      pcfc_pkg::REG_SBY: rd_val[0] = s_r.sby_keep;
      pcfc_pkg::REG_RUN: rd_val[0] = s_r.run;
      pcfc_pkg::REG_FLL_EN: rd_val[0] = s_r.fll_en;
      pcfc_pkg::REG_FLL_MUL: rd_val = s_r.fll_mul;
      pcfc_pkg::REG_STAT: rd_val[pcfc_pkg::STAT_STABLE_BIT] = s_r.stable;
      default: rd_val = pcfc_pkg::RST_BYTE;
    endcase
    for (int i = 0; i < pcfc_pkg::NCH; i++)
    begin
      if (bus.addr == pcfc_pkg::CH_SEL_REG[i])
        rd_val[3:0] = s_r.sel[i];
      if (bus.addr == pcfc_pkg::CH_DIV_REG[i])
        rd_val[2:0] = s_r.div[i];
    end
  end

  // next state: straps, oscillator start-up, register writes
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.strap_s1 = {1'b1, fast_osc_boot_enable_in, option_word_select_in,
                      opt_word_sec_freq_in, opt_word_ns_freq_in};
    s_nxt.strap_s2 = s_r.strap_s1;
    // straps are caught once, three edges after release
    if (s_r.strap_s2[8] && !s_r.loaded)
    begin
      s_nxt.loaded = 1'b1;
      s_nxt.freq = s_r.strap_s2[6] ? s_r.strap_s2[5:3] : s_r.strap_s2[2:0];
      s_nxt.run = !s_r.strap_s2[7];
    end
    // oscillator needs its regulator; any stop restarts the count
    if (!s_r.run || s_r.ldo_stop)
    begin
      s_nxt.stab_cnt = 8'h00;
      s_nxt.stable = 1'b0;
    end
    else if (s_r.stab_cnt == pcfc_pkg::OSC_STAB_CYC)
      s_nxt.stable = 1'b1;
    else
      s_nxt.stab_cnt = s_r.stab_cnt + 8'h01;
    // one access per request; ack blocks a second take of it
    if (bus.req && !s_r.ack)
    begin
      s_nxt.ack = 1'b1;
      s_nxt.rdata = rd_val;
      if (bus.we && bus.addr == pcfc_pkg::REG_WPROT)
        s_nxt.wprot = bus.wdata[1:0];
      // locked writes are dropped but still acked
      if (bus.we && s_r.wprot[pcfc_pkg::WP_CLK_BIT])
      begin
        for (int i = 0; i < pcfc_pkg::NCH; i++)
        begin
          if (bus.addr == pcfc_pkg::CH_SEL_REG[i])
            s_nxt.sel[i] = bus.wdata[3:0];
          if (bus.addr == pcfc_pkg::CH_DIV_REG[i])
            s_nxt.div[i] = bus.wdata[2:0];
        end
        case (bus.addr)
          pcfc_pkg::REG_CKO: s_nxt.cko = bus.wdata;
          pcfc_pkg::REG_FREQ: s_nxt.freq = bus.wdata[2:0];
          pcfc_pkg::REG_SBY: s_nxt.sby_keep = bus.wdata[pcfc_pkg::ONE_BIT];
          pcfc_pkg::REG_RUN: s_nxt.run = bus.wdata[pcfc_pkg::ONE_BIT];
          pcfc_pkg::REG_FLL_EN: s_nxt.fll_en = bus.wdata[pcfc_pkg::ONE_BIT];
          pcfc_pkg::REG_FLL_MUL: s_nxt.fll_mul = bus.wdata;
          default: s_nxt.fll_mul = s_r.fll_mul;
        endcase
      end
      if (bus.we && s_r.wprot[pcfc_pkg::WP_LP_BIT] && bus.addr == pcfc_pkg::REG_LDO)
      begin
        s_nxt.ldo_stop = bus.wdata[pcfc_pkg::LDO_STOP_BIT];
        s_nxt.ldo_keep = bus.wdata[pcfc_pkg::LDO_KEEP_BIT];
      end
    end
  end

  // state register
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // oscillator rate follows the frequency field
  pcfc_tick_div u_osc (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .run_in(s_r.stable),
    .tick_in(1'b1),
    .div_in(s_r.freq),
    .tick_out(osc_tick),
    .level_out()
  );

  // peripheral channels; a channel whose source is silent just stops
  for (genvar g = 0; g < pcfc_pkg::NCH; g++)
  begin : g_ch
    pcfc_tick_div u_div (
      .clock_in(clock_in),
      .reset_n_in(reset_n_in),
      .run_in(1'b1),
      .tick_in(src_ticks[s_r.sel[g]]),
      .div_in(s_r.div[g]),
      .tick_out(ch_tick[g]),
      .level_out()
    );
  end

  // pin divider held in reset while disabled
  pcfc_tick_div u_cko (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .run_in(s_r.cko[pcfc_pkg::CKO_EN_BIT]),
    .tick_in(src_ticks[s_r.cko[2:0]]),
    .div_in(s_r.cko[6:4]),
    .tick_out(),
    .level_out(cko_level)
  );

  assign external_clock_output_out = cko_level & s_r.cko[pcfc_pkg::CKO_EN_BIT];
  assign external_clock_output_oe_out = s_r.cko[pcfc_pkg::CKO_EN_BIT];
  assign usb_fixed_rate_clock_out = ch_tick[0];
  assign usb_hs_controller_clock_out = ch_tick[1];
  assign i3c_clock_out = ch_tick[2];
  assign fast_osc_stable_flag_out = s_r.stable;
  assign bus.ack = s_r.ack;
  assign bus.rdata = s_r.rdata;
endmodule
`default_nettype wire

// ### logic/pcfc_ctrl_host.sv
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module pcfc_ctrl_host (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // register port to the clock block
  pcfc_if.host bus
);
  typedef enum logic [4:0] {
    H_IDLE,
    S_UNLOCK,
    S_CHK_LDO,
    S_FREQ,
    S_SBY,
    S_LDO_KEEP,
    S_MUL,
    S_FLL,
    S_RUN,
    S_POLL,
    S_FLL_WAIT,
    S_RECHECK,
    S_RELOCK,
    A_UNLOCK,
    A_OFF,
    A_DO,
    A_RELOCK
  } pcfc_hst_t;
  typedef struct packed {
    pcfc_hst_t st; // sequencer state
    logic use_fll; // trim with frequency lock
    logic keep_sby; // keep running in standby
    logic [2:0] freq; // frequency to program
    logic [7:0] mul; // lock multiplier
    logic [3:0] acc_addr; // single access target
    logic [7:0] acc_data;
    logic acc_we;
    logic busy;
    logic done;
    logic err; // regulator found stopped
    logic stable_seen;
    logic [7:0] acc_rdata; // last read answer
    logic [31:0] prdata; // apb read data
    logic [7:0] wait_cnt; // lock wait counter
    logic [7:0] cko_last; // last pin control sent; only this end writes it
  } pcfc_host_t;
  pcfc_host_t h_r;
  pcfc_host_t h_nxt;
  logic [31:0] apb_rd; // apb read mux
  logic mapped; // offset decodes
  logic apb_wr; // write access phase
  logic ack; // bus answer this cycle

  assign ack = bus.ack;
  assign apb_wr = psel_in && penable_in && pwrite_in;
  assign mapped = (paddr_in == pcfc_pkg::APB_CTRL) || (paddr_in == pcfc_pkg::APB_STAT) ||
                  (paddr_in == pcfc_pkg::APB_ACC) || (paddr_in == pcfc_pkg::APB_RDATA);

  // bus request per state; held until the device acks
  always_comb
  begin
    bus.req = 1'b1;
    bus.we = 1'b1;
    bus.addr = pcfc_pkg::REG_WPROT;
    bus.wdata = pcfc_pkg::RST_BYTE;
    case (h_r.st)
      S_UNLOCK, A_UNLOCK:
        bus.wdata[1:0] = pcfc_pkg::WP_UNLOCK_ALL;
      S_CHK_LDO:
      begin
        bus.we = 1'b0;
        bus.addr = pcfc_pkg::REG_LDO;
      end
      S_FREQ:
      begin
        bus.addr = pcfc_pkg::REG_FREQ;
        bus.wdata[2:0] = h_r.freq;
      end
      S_SBY:
      begin
        bus.addr = pcfc_pkg::REG_SBY;
        bus.wdata[pcfc_pkg::ONE_BIT] = 1'b1;
      end
      S_LDO_KEEP:
      begin
        bus.addr = pcfc_pkg::REG_LDO;
        bus.wdata[pcfc_pkg::LDO_KEEP_BIT] = 1'b1;
      end
      S_MUL:
      begin
        bus.addr = pcfc_pkg::REG_FLL_MUL;
        bus.wdata = h_r.mul;
      end
      S_FLL:
      begin
        bus.addr = pcfc_pkg::REG_FLL_EN;
        bus.wdata[pcfc_pkg::ONE_BIT] = 1'b1;
      end
      S_RUN:
      begin
        bus.addr = pcfc_pkg::REG_RUN;
        bus.wdata[pcfc_pkg::ONE_BIT] = 1'b1;
      end
      S_POLL, S_RECHECK:
      begin
        bus.we = 1'b0;
        bus.addr = pcfc_pkg::REG_STAT;
      end
      S_RELOCK, A_RELOCK:
        bus.wdata = pcfc_pkg::RST_BYTE;
      A_OFF:
      begin
        // pin output off first so divider/select change while disabled
        // old divider and select kept, so only the enable bit moves here
        bus.addr = pcfc_pkg::REG_CKO;
        bus.wdata = h_r.cko_last;
        bus.wdata[pcfc_pkg::CKO_EN_BIT] = 1'b0;
      end
      A_DO:
      begin
        // software picks the usb rates; they pass unchanged
        bus.we = h_r.acc_we;
        bus.addr = h_r.acc_addr;
        bus.wdata = h_r.acc_data;
      end
      default:
        bus.req = 1'b0;
    endcase
  end

  // apb read mux
  always_comb
  begin
    apb_rd = pcfc_pkg::RST_WORD;
    case (paddr_in)
      pcfc_pkg::APB_CTRL:
      begin
        apb_rd[pcfc_pkg::CTL_FLL_BIT] = h_r.use_fll;
        apb_rd[pcfc_pkg::CTL_SBY_BIT] = h_r.keep_sby;
        apb_rd[pcfc_pkg::CTL_FREQ_LSB +: 3] = h_r.freq;
        apb_rd[pcfc_pkg::CTL_MUL_LSB +: 8] = h_r.mul;
      end
      pcfc_pkg::APB_STAT:
      begin
        apb_rd[pcfc_pkg::ST_BUSY_BIT] = h_r.busy;
        apb_rd[pcfc_pkg::ST_DONE_BIT] = h_r.done;
        apb_rd[pcfc_pkg::ST_ERR_BIT] = h_r.err;
        apb_rd[pcfc_pkg::ST_STABLE_BIT] = h_r.stable_seen;
      end
      pcfc_pkg::APB_ACC:
      begin
        apb_rd[3:0] = h_r.acc_addr;
        apb_rd[pcfc_pkg::ACC_DATA_LSB +: 8] = h_r.acc_data;
        apb_rd[pcfc_pkg::ACC_WE_BIT] = h_r.acc_we;
      end
      pcfc_pkg::APB_RDATA:
        apb_rd[7:0] = h_r.acc_rdata;
      default:
        apb_rd = pcfc_pkg::RST_WORD;
    endcase
  end

  // sequencer and apb register writes
  always_comb
  begin
    h_nxt = h_r;
    case (h_r.st)
      H_IDLE:
        h_nxt.st = H_IDLE;
      S_UNLOCK:
        if (ack)
          h_nxt.st = S_CHK_LDO;
      S_CHK_LDO:
        if (ack)
        begin
          // stopped regulator: abort but still relock
          if (bus.rdata[pcfc_pkg::LDO_STOP_BIT])
          begin
            h_nxt.err = 1'b1;
            h_nxt.st = S_RELOCK;
          end
          else
            h_nxt.st = S_FREQ;
        end
      S_FREQ:
        if (ack)
          h_nxt.st = h_r.keep_sby ? S_SBY : (h_r.use_fll ? S_MUL : S_RUN);
      S_SBY:
        if (ack)
          h_nxt.st = S_LDO_KEEP;
      S_LDO_KEEP:
        if (ack)
          h_nxt.st = h_r.use_fll ? S_MUL : S_RUN;
      S_MUL:
        if (ack)
          h_nxt.st = S_FLL;
      S_FLL:
        if (ack)
          h_nxt.st = S_RUN;
      S_RUN:
        if (ack)
          h_nxt.st = S_POLL;
      S_POLL:
        // a clear flag simply reissues the read
        if (ack && bus.rdata[pcfc_pkg::STAT_STABLE_BIT])
        begin
          h_nxt.stable_seen = 1'b1;
          h_nxt.wait_cnt = 8'h00;
          h_nxt.st = h_r.use_fll ? S_FLL_WAIT : S_RELOCK;
        end
      S_FLL_WAIT:
        if (h_r.wait_cnt == pcfc_pkg::FLL_WAIT_CYC)
          h_nxt.st = S_RECHECK;
        else
          h_nxt.wait_cnt = h_r.wait_cnt + 8'h01;
      S_RECHECK:
        if (ack)
          h_nxt.st = bus.rdata[pcfc_pkg::STAT_STABLE_BIT] ? S_RELOCK : S_POLL;
      S_RELOCK, A_RELOCK:
        if (ack)
        begin
          h_nxt.st = H_IDLE;
          h_nxt.busy = 1'b0;
          h_nxt.done = 1'b1;
        end
      A_UNLOCK:
        if (ack)
          h_nxt.st = (h_r.acc_we && h_r.acc_addr == pcfc_pkg::REG_CKO) ? A_OFF : A_DO;
      A_OFF:
        if (ack)
          h_nxt.st = A_DO;
      A_DO:
        if (ack)
        begin
          h_nxt.acc_rdata = bus.rdata;
          h_nxt.st = A_RELOCK;
          // remember the pin setting for the next disable step
          if (h_r.acc_we && h_r.acc_addr == pcfc_pkg::REG_CKO)
            h_nxt.cko_last = h_r.acc_data;
        end
      default:
        h_nxt.st = H_IDLE;
    endcase
    // read data captured in the setup cycle for a zero-wait access
    if (psel_in && !penable_in)
      h_nxt.prdata = apb_rd;
    // orders are refused while a sequence runs
    if (apb_wr && !h_r.busy && paddr_in == pcfc_pkg::APB_CTRL)
    begin
      h_nxt.use_fll = pwdata_in[pcfc_pkg::CTL_FLL_BIT];
      h_nxt.keep_sby = pwdata_in[pcfc_pkg::CTL_SBY_BIT];
      h_nxt.freq = pwdata_in[pcfc_pkg::CTL_FREQ_LSB +: 3];
      h_nxt.mul = pwdata_in[pcfc_pkg::CTL_MUL_LSB +: 8];
      if (pwdata_in[pcfc_pkg::CTL_START_BIT])
      begin
        h_nxt.busy = 1'b1;
        h_nxt.done = 1'b0;
        h_nxt.err = 1'b0;
        h_nxt.stable_seen = 1'b0;
        h_nxt.st = S_UNLOCK;
      end
    end
    if (apb_wr && !h_r.busy && paddr_in == pcfc_pkg::APB_ACC)
    begin
      h_nxt.acc_addr = pwdata_in[3:0];
      h_nxt.acc_data = pwdata_in[pcfc_pkg::ACC_DATA_LSB +: 8];
      h_nxt.acc_we = pwdata_in[pcfc_pkg::ACC_WE_BIT];
      if (pwdata_in[pcfc_pkg::ACC_GO_BIT])
      begin
        h_nxt.busy = 1'b1;
        h_nxt.done = 1'b0;
        h_nxt.st = A_UNLOCK;
      end
    end
  end

  // state register
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      h_r <= '0;
    else
      h_r <= h_nxt;
  end

  assign prdata_out = h_r.prdata;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;
endmodule
`default_nettype wire

// ### bench/pcfc_checker.sv
`timescale 1ns/1ns
`default_nettype none
module pcfc_checker (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // register port between the two ends
  input wire logic req,
  input wire logic we,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ack
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);
  // a request is taken when no answer is pending
  wire take = req && !ack;
  // mirrors of protect bits and pin control
  logic [1:0] wp_r;
  logic [7:0] cko_r;
  // progress of the start sequence, cleared by any protect write; rdwp_r and rdst_r flag last cycle's reads
  logic frq_r, ldo_r, mul_r, rdwp_r, rdst_r;
  // helper state follows what the clock block takes
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      {wp_r, cko_r, frq_r, ldo_r, mul_r, rdwp_r, rdst_r} <= 15'h0000;
    end
    else
    begin
      rdwp_r <= take && !we && addr == pcfc_pkg::REG_WPROT;
      rdst_r <= take && !we && addr == pcfc_pkg::REG_STAT;
      if (take && we && addr == pcfc_pkg::REG_WPROT)
      begin
        wp_r <= wdata[1:0];
        {frq_r, ldo_r, mul_r} <= 3'h0;
      end
      if (take && we && addr == pcfc_pkg::REG_CKO)
        cko_r <= wdata;
      if (take && we && addr == pcfc_pkg::REG_FREQ)
        frq_r <= 1'h1;
      if (take && !we && addr == pcfc_pkg::REG_LDO)
        ldo_r <= 1'h1;
      if (take && we && addr == pcfc_pkg::REG_FLL_MUL)
        mul_r <= 1'h1;
    end
  end
  property p_answer;
    take |=> ack && req && $stable(addr) && $stable(wdata);
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered next cycle");
  property p_pulse;
    ack |=> !ack;
  endproperty
  a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
  property p_cause;
    ack |-> $past(take);
  endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  property p_unlock;
    take && we && addr != pcfc_pkg::REG_WPROT |-> wp_r == 2'h3;
  endproperty
  a_unlock: assert property (p_unlock) else $error("write while protected");
  property p_run_last;
    take && we && addr == pcfc_pkg::REG_RUN && wdata[0] |-> frq_r && ldo_r;
  endproperty
  a_run_last: assert property (p_run_last) else $error("start before checks");
  property p_fll;
    take && we && addr == pcfc_pkg::REG_FLL_EN && wdata[0] |-> mul_r;
  endproperty
  a_fll: assert property (p_fll) else $error("lock enable before multiplier");
  property p_cko;
    take && we && addr == pcfc_pkg::REG_CKO && cko_r[7] |-> wdata[6:0] == cko_r[6:0];
  endproperty
  a_cko: assert property (p_cko) else $error("pin setting changed while enabled");
  property p_wp_read;
    ack && rdwp_r |-> rdata == {6'h00, wp_r};
  endproperty
  a_wp_read: assert property (p_wp_read) else $error("protect read wrong");
  property p_stat;
    ack && rdst_r |-> rdata[7:1] == 7'h00;
  endproperty
  a_stat: assert property (p_stat) else $error("status spare bits set");
  // main scenarios
  c_run: cover property (take && we && addr == pcfc_pkg::REG_RUN);
  c_cko: cover property (take && we && addr == pcfc_pkg::REG_CKO && wdata[7]);
  c_stable: cover property (ack && rdst_r && rdata[0]);
endmodule
`default_nettype wire

// ### bench/pcfc_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module pcfc_tb_top;
  // clock, reset and apb master
  logic clock_in = 1'h0;
  logic reset_n_in = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  // generated ticks, pin and status
  logic [2:0] tk;
  logic cko, cko_oe, stable;
  wire [3:0] outs = {cko, tk};
  int n_errors = 0;
  int comparisons = 0;
  pcfc_if link ();
  pcfc_ctrl_host pcfc_ctrl_host_inst (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .bus(link.host));
  // straps: secure word selected, oscillator stopped at boot
  pcfc_clk_dev pcfc_clk_dev_inst (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .bus(link.dev), .opt_word_ns_freq_in(3'h5), .opt_word_sec_freq_in(3'h2),
    .option_word_select_in(1'h1), .fast_osc_boot_enable_in(1'h1),
    .src_tick_in(14'h0000), .usb_fixed_rate_clock_out(tk[0]),
    .usb_hs_controller_clock_out(tk[1]), .i3c_clock_out(tk[2]),
    .external_clock_output_out(cko), .external_clock_output_oe_out(cko_oe),
    .fast_osc_stable_flag_out(stable));
  pcfc_checker pcfc_checker_inst (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .req(link.req), .we(link.we), .addr(link.addr), .wdata(link.wdata),
    .rdata(link.rdata), .ack(link.ack));
  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer; an idle edge first keeps drives single per step
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clock_in);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'h1;
    do
      @(posedge clock_in);
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // poll controller status until not busy, bounded
  task automatic wait_idle();
    for (int i = 0; i < 400; i++)
    begin
      apb(pcfc_pkg::APB_STAT, 1'h0, 32'h0000_0000);
      if (rd[pcfc_pkg::ST_BUSY_BIT] === 1'h0)
        break;
    end
    // a poll limit that runs out counts as a mismatch
    check("idle", rd[pcfc_pkg::ST_BUSY_BIT], 1'h0);
  endtask
  // single register access through the controller, result in rd
  task automatic dev_acc(input logic [3:0] a, input logic w, input logic [7:0] d);
    apb(pcfc_pkg::APB_ACC, 1'h1, {1'h1, 14'h0000, w, d, 4'h0, a});
    wait_idle();
    apb(pcfc_pkg::APB_RDATA, 1'h0, 32'h0000_0000);
  endtask
  // count cycles an output is high over a window
  task automatic count(input string what, input int k, input int cyc, input int exp);
    int n;
    n = 0;
    repeat (cyc)
    begin
      @(posedge clock_in);
      if (outs[k] === 1'h1)
        n++;
    end
    check(what, n, exp);
  endtask
  task automatic s_boot();
    check("stable at boot", stable, 1'h0);
    dev_acc(pcfc_pkg::REG_FREQ, 1'h0, 8'h00);
    check("boot freq", rd, 32'h0000_0002);
    dev_acc(pcfc_pkg::REG_RUN, 1'h0, 8'h00);
    check("boot run", rd, 32'h0000_0000);
    // a single access runs unlocked, so both protect bits read set
    dev_acc(pcfc_pkg::REG_WPROT, 1'h0, 8'h00);
    check("protect open", rd, 32'h0000_0003);
    apb(12'h010, 1'h1, 32'h0000_0077);
    check("unmapped", err, 1'h1);
  endtask
  // regulator stopped: start must end in error
  task automatic s_ldo();
    dev_acc(pcfc_pkg::REG_LDO, 1'h1, 8'h01);
    apb(pcfc_pkg::APB_CTRL, 1'h1, 32'h0000_0001);
    wait_idle();
    check("stop error", rd[pcfc_pkg::ST_ERR_BIT], 1'h1);
    check("stable", stable, 1'h0);
    dev_acc(pcfc_pkg::REG_LDO, 1'h1, 8'h00);
  endtask
  // full start with lock, standby keep, freq 3, multiplier 0x10
  task automatic s_start();
    logic [3:0] ra [7] = '{pcfc_pkg::REG_FREQ, pcfc_pkg::REG_SBY, pcfc_pkg::REG_LDO,
      pcfc_pkg::REG_FLL_EN, pcfc_pkg::REG_FLL_MUL, pcfc_pkg::REG_STAT, pcfc_pkg::REG_RUN};
    logic [7:0] rv [7] = '{8'h03, 8'h01, 8'h02, 8'h01, 8'h10, 8'h01, 8'h01};
    apb(pcfc_pkg::APB_CTRL, 1'h1, 32'h0000_1037);
    wait_idle();
    check("start status", rd[3:0], 4'hA);
    check("stable", stable, 1'h1);
    for (int i = 0; i < 7; i++)
    begin
      dev_acc(ra[i], 1'h0, 8'h00);
      check("setting", rd, {24'h00_0000, rv[i]});
    end
  endtask
  // pin output: enabled, retuned, disabled
  task automatic s_cko();
    check("pin idle", {cko_oe, cko}, 2'h0);
    dev_acc(pcfc_pkg::REG_CKO, 1'h1, 8'h90);
    check("pin enable", cko_oe, 1'h1);
    count("pin high", 3, 16, 8);
    dev_acc(pcfc_pkg::REG_CKO, 1'h1, 8'hA0);
    count("pin high", 3, 18, 9);
    dev_acc(pcfc_pkg::REG_CKO, 1'h1, 8'h20);
    check("pin off", {cko_oe, cko}, 2'h0);
  endtask
  // each channel: select and divider, osc tick every 4 cycles
  task automatic s_div();
    int sv [3] = '{0, 1, 0};
    int dv [3] = '{2, 1, 5};
    int ex [3] = '{8, 3, 4};
    for (int i = 0; i < 3; i++)
    begin
      dev_acc(pcfc_pkg::CH_SEL_REG[i], 1'h1, 8'(sv[i]));
      dev_acc(pcfc_pkg::CH_DIV_REG[i], 1'h1, 8'(dv[i]));
      count("divided tick", i, 24, ex[i]);
    end
    // a silent external source leaves the usb clock stopped
    dev_acc(pcfc_pkg::REG_USB_SEL, 1'h1, 8'h02);
    count("stopped usb", 0, 24, 0);
  endtask
  task automatic end_sim();
    if (n_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    forever #25 clock_in = ~clock_in;
  end
  // watchdog well beyond the few hundred cycles needed
  initial
  begin
    repeat (20000) @(posedge clock_in);
    n_errors++;
    end_sim();
  end
  initial
  begin
    repeat (12) @(posedge clock_in);
    reset_n_in <= 1'h1;
    s_boot();
    s_ldo();
    s_start();
    s_cko();
    s_div();
    end_sim();
  end
endmodule
`default_nettype wire
